// ===== ipf_ea_cost.sv
// Timing package and effective-address cost lookup for the prefetch unit
`default_nettype none

package ipf_pkg;
    localparam int ADDR_W = 20;
    // Bus cycle budget at 250 MHz
    localparam int CLK_PERIOD_PS = 4000;
    localparam int BUS_CYCLE_NS = 16;
    localparam int BUS_CYCLE_CLK = (BUS_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [2:0] BUS_LAST_PHASE = 3'(BUS_CYCLE_CLK - 1);
    // Move instruction base: opcode word fetch plus next prefetch
    localparam logic [7:0] MOVE_BASE_CLK = 8'h08;
    localparam logic [3:0] MOVE_BASE_RD = 4'h2;
    // Memory operand access, byte then word
    localparam logic [7:0] OPND_CLK [2] = '{8'h04, 8'h08};
    localparam logic [3:0] OPND_CYC [2] = '{4'h1, 4'h2};
    localparam logic [19:0] WORD_STEP = 20'h00002;

    typedef enum logic [3:0] {
        IPF_DREG, IPF_AREG, IPF_IND, IPF_POSTINC, IPF_PREDEC, IPF_DISP,
        IPF_INDEX, IPF_ABSW, IPF_ABSL, IPF_PCDISP, IPF_PCINDEX, IPF_IMM
    } ipf_mode_t;
    typedef enum logic [1:0] {IPF_BYTE, IPF_WORD, IPF_LONG} ipf_size_t;
    typedef enum logic {IPF_BUS_IDLE, IPF_BUS_RUN} ipf_bus_t;

    // Effective-address cost, rows by mode, columns byte/word/long
    localparam logic [7:0] EA_CLK [12][3] = '{
        '{8'h00, 8'h00, 8'h00}, '{8'h00, 8'h00, 8'h00},
        '{8'h04, 8'h08, 8'h10}, '{8'h04, 8'h08, 8'h10},
        '{8'h06, 8'h0a, 8'h12}, '{8'h0c, 8'h10, 8'h18},
        '{8'h0e, 8'h12, 8'h1a}, '{8'h0c, 8'h10, 8'h18},
        '{8'h14, 8'h18, 8'h20}, '{8'h0c, 8'h10, 8'h18},
        '{8'h0e, 8'h12, 8'h1a}, '{8'h08, 8'h08, 8'h10}};
    localparam logic [3:0] EA_RD [12][3] = '{
        '{4'h0, 4'h0, 4'h0}, '{4'h0, 4'h0, 4'h0},
        '{4'h1, 4'h2, 4'h4}, '{4'h1, 4'h2, 4'h4},
        '{4'h1, 4'h2, 4'h4}, '{4'h3, 4'h4, 4'h6},
        '{4'h3, 4'h4, 4'h6}, '{4'h3, 4'h4, 4'h6},
        '{4'h5, 4'h6, 4'h8}, '{4'h3, 4'h4, 4'h6},
        '{4'h3, 4'h4, 4'h6}, '{4'h2, 4'h2, 4'h4}};
endpackage

module ipf_ea_cost (
    // Query
    input wire ipf_pkg::ipf_mode_t mode,
    input wire ipf_pkg::ipf_size_t size,
    // Cost
    output logic [7:0] clocks,
    output logic [3:0] reads
);
    import ipf_pkg::*;

    always_comb begin
        clocks = 8'h00;
        reads = 4'h0;
        // Illegal codes cost nothing
        if (mode <= IPF_IMM && size <= IPF_LONG) begin
            clocks = EA_CLK[mode][size];
            reads = EA_RD[mode][size];
        end
    end
endmodule

`default_nettype wire

// ===== ipf_prefetch.sv
// Two-word instruction prefetch queue with byte bus sequencing and cycle accounting
// Operation
// - Keep a two-word instruction prefetch queue tied to execution.
// - Entry ready only with opword in decoder and next word fetched.
// - Each consumed extension word triggers a refetch into its slot.
// - Discarding the opword starts the last fetch for that instruction.
// - Branching single-word instructions waste the already fetched second word.
// - Interrupt or trace exception uses neither queued word.
// - Program counter holds address of last fetched stream word.
// - Each read or write bus cycle takes four clocks nominally.
// - Wait states add clocks beyond the budgeted figure.
// - Counts include all fetches, paired with read and write cycle counts.
// - Effective-address processing issues reads only, never writes.
// - Indirect and postincrement cost 4(1/0), 8(2/0), 16(4/0).
// - Predecrement costs 6(1/0), 10(2/0), 18(4/0).
// - Displacement costs 12(3/0), 16(4/0), 24(6/0).
// - PC-relative indexed costs 14(3/0), 18(4/0), 26(6/0).
// - Index register size does not change timing.
// - Byte move register-register 8(2/0); data register to absolute long 28(6/1).
// - Word move register to indirect (2/2); indirect to register 16(4/0).
`default_nettype none

module ipf_prefetch (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Execution unit handshake
    input wire logic nextInstr,
    input wire logic consumeExt,
    input wire logic branchTaken,
    input wire logic exceptTaken,
    input wire logic [ipf_pkg::ADDR_W-1:0] flowTarget,
    output logic entryReady,
    output logic opValid,
    output logic extValid,
    output logic [15:0] opWord,
    output logic [15:0] extWord,
    output logic [ipf_pkg::ADDR_W-1:0] progCounter,
    // Operand byte access
    input wire logic opReq,
    input wire logic opWrite,
    input wire logic [ipf_pkg::ADDR_W-1:0] opAddr,
    input wire logic [7:0] opWData,
    output logic opDone,
    output logic [7:0] opRData,
    // Byte memory
    output logic memReq,
    output logic memWrite,
    output logic [ipf_pkg::ADDR_W-1:0] memAddr,
    output logic [7:0] memWData,
    input wire logic memAck,
    input wire logic [7:0] memRData,
    // Timing budget query
    input wire logic eaStart,
    input wire logic moveStart,
    input wire ipf_pkg::ipf_mode_t srcMode,
    input wire ipf_pkg::ipf_mode_t dstMode,
    input wire ipf_pkg::ipf_size_t opSize,
    output logic [7:0] budgetClocks,
    output logic [3:0] budgetReads,
    output logic [3:0] budgetWrites,
    // Measured cost of the last finished instruction
    output logic [15:0] lastClocks,
    output logic [7:0] lastReads,
    output logic [7:0] lastWrites,
    output logic [15:0] lastWaits
);
    import ipf_pkg::*;

    typedef struct packed {
        ipf_bus_t bus;
        logic [2:0] phase;
        logic opCyc;
        logic lowByte;
        logic drop;
        logic needAckLow;
        logic ackS1;
        logic ackS2;
        logic [7:0] datS1;
        logic [7:0] datS2;
        logic memReq;
        logic memWrite;
        logic [ADDR_W-1:0] memAddr;
        logic [7:0] memWData;
        logic [7:0] hiByte;
        logic [1:0][15:0] q;
        logic [1:0] qv;
        logic [ADDR_W-1:0] fetchAddr;
        logic [ADDR_W-1:0] pc;
        logic entryReady;
        logic opDone;
        logic [7:0] opRData;
        logic [15:0] clkCnt;
        logic [7:0] rdCnt;
        logic [7:0] wrCnt;
        logic [15:0] waitCnt;
        logic [15:0] lastClk;
        logic [7:0] lastRd;
        logic [7:0] lastWr;
        logic [15:0] lastWait;
        logic [7:0] budClk;
        logic [3:0] budRd;
        logic [3:0] budWr;
    } ipf_state_t;

    ipf_state_t st_q;
    ipf_state_t st_d;

    logic [7:0] srcClk;
    logic [3:0] srcRd;
    logic [7:0] dstClk;
    logic [3:0] dstRd;
    ipf_mode_t dstLookup;
    logic sizeIdx;

    // Predecrement destination costs as plain indirect
    assign dstLookup = (dstMode == IPF_PREDEC) ? IPF_IND : dstMode;
    assign sizeIdx = (opSize != IPF_BYTE);

    ipf_ea_cost srcCost (
        .mode(srcMode),
        .size(opSize),
        .clocks(srcClk),
        .reads(srcRd)
    );

    ipf_ea_cost dstCost (
        .mode(dstLookup),
        .size(opSize),
        .clocks(dstClk),
        .reads(dstRd)
    );

    always_comb begin
        logic busEnd;
        logic wordDone;
        logic flush;
        logic dstMem;
        busEnd = 1'b0;
        wordDone = 1'b0;
        dstMem = 1'b0;
        flush = branchTaken || exceptTaken;
        st_d = st_q;
        st_d.opDone = 1'b0;
        st_d.ackS1 = memAck;
        st_d.ackS2 = st_q.ackS1;
        st_d.datS1 = memRData;
        st_d.datS2 = st_q.datS1;
        st_d.clkCnt = st_q.clkCnt + 16'h0001;

        // Queue consumption by the execution unit
        if (nextInstr && st_q.qv[0]) begin
            st_d.q[0] = st_q.q[1];
            st_d.qv = {1'b0, st_q.qv[1]};
            st_d.lastClk = st_d.clkCnt;
            st_d.lastRd = st_q.rdCnt;
            st_d.lastWr = st_q.wrCnt;
            st_d.lastWait = st_q.waitCnt;
            st_d.clkCnt = 16'h0001;
            st_d.rdCnt = 8'h00;
            st_d.wrCnt = 8'h00;
            st_d.waitCnt = 16'h0000;
        end else if (consumeExt && st_q.qv[1]) begin
            st_d.qv[1] = 1'b0;
        end

        // Branch or exception empties the queue
        if (flush) begin
            st_d.qv = 2'b00;
            st_d.fetchAddr = flowTarget;
            st_d.drop = (st_q.bus == IPF_BUS_RUN && !st_q.opCyc) || st_q.lowByte;
        end

        // Running bus cycle
        if (st_q.bus == IPF_BUS_RUN) begin
            if (st_q.phase != BUS_LAST_PHASE) begin
                st_d.phase = st_q.phase + 3'h1;
            end else if (st_q.ackS2) begin
                busEnd = 1'b1;
            end else begin
                st_d.waitCnt = st_q.waitCnt + 16'h0001;
            end
        end

        if (busEnd) begin
            st_d.bus = IPF_BUS_IDLE;
            st_d.memReq = 1'b0;
            st_d.needAckLow = 1'b1;
            if (st_q.memWrite) begin
                st_d.wrCnt = st_q.wrCnt + 8'h01;
            end else begin
                st_d.rdCnt = st_q.rdCnt + 8'h01;
            end
            if (st_q.opCyc) begin
                st_d.opDone = 1'b1;
                st_d.opRData = st_q.datS2;
            end else if (!st_q.lowByte) begin
                st_d.hiByte = st_q.datS2;
                st_d.lowByte = 1'b1;
            end else begin
                st_d.lowByte = 1'b0;
                wordDone = 1'b1;
            end
        end

        // Completed word lands in the first free slot
        if (wordDone) begin
            if (st_q.drop || flush) begin
                st_d.drop = flush;
            end else begin
                if (!st_d.qv[0]) begin
                    st_d.q[0] = {st_q.hiByte, st_q.datS2};
                    st_d.qv[0] = 1'b1;
                end else begin
                    st_d.q[1] = {st_q.hiByte, st_q.datS2};
                    st_d.qv[1] = 1'b1;
                end
                st_d.pc = st_q.fetchAddr;
                st_d.fetchAddr = st_q.fetchAddr + WORD_STEP;
            end
        end

        // Ack must fall before the next cycle starts
        if (st_q.needAckLow && !st_q.ackS2) begin
            st_d.needAckLow = 1'b0;
        end

        // Start a new byte cycle
        if (st_q.bus == IPF_BUS_IDLE && !st_q.needAckLow && !busEnd) begin
            if (opReq && !st_q.opDone && !st_q.lowByte) begin
                st_d.bus = IPF_BUS_RUN;
                st_d.opCyc = 1'b1;
                st_d.memWrite = opWrite;
                st_d.memAddr = opAddr;
                st_d.memWData = opWData;
                st_d.memReq = 1'b1;
                st_d.phase = 3'h0;
            end else if (st_q.lowByte || !(&st_d.qv)) begin
                st_d.bus = IPF_BUS_RUN;
                st_d.opCyc = 1'b0;
                st_d.memWrite = 1'b0;
                st_d.memAddr = st_q.lowByte ? st_q.fetchAddr + 20'h00001 : st_d.fetchAddr;
                st_d.memReq = 1'b1;
                st_d.phase = 3'h0;
            end
        end

        st_d.entryReady = &st_d.qv;

        // Budget from the timing tables
        if (eaStart) begin
            st_d.budClk = srcClk;
            st_d.budRd = srcRd;
            st_d.budWr = 4'h0;
        end else if (moveStart) begin
            dstMem = (dstMode != IPF_DREG) && (dstMode != IPF_AREG);
            st_d.budClk = MOVE_BASE_CLK + srcClk;
            st_d.budRd = MOVE_BASE_RD + srcRd;
            st_d.budWr = 4'h0;
            if (dstMem) begin
                st_d.budClk = MOVE_BASE_CLK + srcClk + dstClk - OPND_CLK[sizeIdx]
                    + OPND_CLK[sizeIdx];
                st_d.budRd = MOVE_BASE_RD + srcRd + dstRd - OPND_CYC[sizeIdx];
                st_d.budWr = OPND_CYC[sizeIdx];
            end
        end

        if (rst) begin
            st_d = '0;
            st_d.bus = IPF_BUS_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    assign entryReady = st_q.entryReady;
    assign opValid = st_q.qv[0];
    assign extValid = st_q.qv[1];
    assign opWord = st_q.q[0];
    assign extWord = st_q.q[1];
    assign progCounter = st_q.pc;
    assign opDone = st_q.opDone;
    assign opRData = st_q.opRData;
    assign memReq = st_q.memReq;
    assign memWrite = st_q.memWrite;
    assign memAddr = st_q.memAddr;
    assign memWData = st_q.memWData;
    assign budgetClocks = st_q.budClk;
    assign budgetReads = st_q.budRd;
    assign budgetWrites = st_q.budWr;
    assign lastClocks = st_q.lastClk;
    assign lastReads = st_q.lastRd;
    assign lastWrites = st_q.lastWr;
    assign lastWaits = st_q.lastWait;
endmodule

`default_nettype wire

// ===== ipf_prefetch_props.sv
// Concurrent checks on the prefetch unit ports
`default_nettype none
module ipf_prefetch_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Queue
    input wire logic nextInstr,
    input wire logic consumeExt,
    input wire logic branchTaken,
    input wire logic exceptTaken,
    input wire logic entryReady,
    input wire logic opValid,
    input wire logic extValid,
    // Bus and budget
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [ipf_pkg::ADDR_W-1:0] memAddr,
    input wire logic eaStart,
    input wire logic moveStart,
    input wire logic [3:0] budgetWrites
);
    timeunit 1ns;
    timeprecision 1ps;
    import ipf_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_busStart;
        $rose(memReq);
    endsequence
    property p_bus_len;
        s_busStart |-> memReq [*4];
    endproperty
    a_bus_len: assert property (p_bus_len) else $error("bus cycle too short");
    property p_bus_hold;
        memReq && $past(memReq) |-> $stable(memAddr) && $stable(memWrite);
    endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus request moved");
    property p_ready;
        entryReady |-> opValid && extValid;
    endproperty
    a_ready: assert property (p_ready) else $error("entry without two words");
    property p_fill;
        $rose(extValid) |-> opValid;
    endproperty
    a_fill: assert property (p_fill) else $error("second slot filled first");
    property p_branch;
        branchTaken |=> !opValid && !extValid;
    endproperty
    a_branch: assert property (p_branch) else $error("queue kept on branch");
    property p_except;
        exceptTaken |=> !opValid && !extValid && !entryReady;
    endproperty
    a_except: assert property (p_except) else $error("queue kept on exception");
    property p_refetch;
        consumeExt && extValid && !nextInstr && !branchTaken && !exceptTaken
            |=> !extValid ##[0:7] s_busStart;
    endproperty
    a_refetch: assert property (p_refetch) else $error("no refetch of used word");
    property p_last;
        nextInstr && entryReady && !branchTaken && !exceptTaken |-> ##[1:9] s_busStart;
    endproperty
    a_last: assert property (p_last) else $error("no fetch after discard");
    property p_ea_nowr;
        eaStart ##1 !moveStart |=> budgetWrites == 4'h0;
    endproperty
    a_ea_nowr: assert property (p_ea_nowr) else $error("address budget writes");
endmodule
bind ipf_prefetch ipf_prefetch_props u_props (
    .clk(clk), .rst(rst), .nextInstr(nextInstr), .consumeExt(consumeExt),
    .branchTaken(branchTaken), .exceptTaken(exceptTaken), .entryReady(entryReady),
    .opValid(opValid), .extValid(extValid), .memReq(memReq), .memWrite(memWrite),
    .memAddr(memAddr), .eaStart(eaStart), .moveStart(moveStart), .budgetWrites(budgetWrites)
);
`default_nettype wire

// ===== ipf_mem_model.sv
// Byte-wide memory model on the prefetch unit bus
`default_nettype none
module ipf_mem_model (
    // Clock, reset and pacing
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    // Byte bus
    input wire logic memReq,
    input wire logic [ipf_pkg::ADDR_W-1:0] memAddr,
    output logic memAck,
    output logic [7:0] memRData
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    int wt = 0;
    logic [7:0] d = 8'h00;
    // Released bus shows inverted data
    assign memRData = (memAck || cnt != 0) ? d : ~d;
    always @(posedge clk) begin
        if (rst || (!memReq && memAck)) begin
            memAck <= 1'b0;
            cnt <= 0;
        end else if (memReq && !memAck) begin
            if (cnt == 0) begin
                d <= memAddr[7:0] ^ memAddr[19:12] ^ 8'ha5;
                wt <= slow ? $urandom_range(5, 0) : 0;
            end
            // Data settles two clocks plus the random wait (wt) before the answer
            if (cnt == 2 + wt) memAck <= 1'b1;
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ===== ipf_prefetch_test.sv
// Self-checking bench for the instruction prefetch unit
`default_nettype none
module ipf_prefetch_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ipf_pkg::*;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0, pr = 1'b0;
    logic nextInstr = 1'b0, consumeExt = 1'b0, branchTaken = 1'b0, exceptTaken = 1'b0;
    logic eaStart = 1'b0, moveStart = 1'b0;
    logic [ADDR_W-1:0] flowTarget = '0, progCounter, memAddr, t, u;
    ipf_mode_t srcMode = IPF_DREG, dstMode = IPF_DREG;
    ipf_size_t opSize = IPF_BYTE;
    logic entryReady, opValid, extValid, memReq, memWrite, memAck;
    logic [15:0] opWord, extWord;
    logic [7:0] memWData, memRData, budgetClocks;
    logic [3:0] budgetReads, budgetWrites;
    logic [1:0] st = 2'b00;
    logic opReq = 1'b0, opWrite = 1'b0, opDone;
    logic [ADDR_W-1:0] opAddr = '0;
    logic [7:0] opWData = 8'h00, opRData, wSeen = 8'h00, lastReads, lastWrites;
    logic [15:0] lastWaits;
    logic [8:0] oe;
    logic [8:0] qo[$];
    logic [51:0] qw[$];
    logic [15:0] qb[$];
    int n_errors = 0, comparisons = 0, cyc = 0;

    always #2 clk = ~clk;

    ipf_prefetch u_dut (.clk(clk), .rst(rst), .nextInstr(nextInstr), .consumeExt(consumeExt),
        .branchTaken(branchTaken), .exceptTaken(exceptTaken), .flowTarget(flowTarget),
        .entryReady(entryReady), .opValid(opValid), .extValid(extValid), .opWord(opWord),
        .extWord(extWord), .progCounter(progCounter), .opReq(opReq), .opWrite(opWrite),
        .opAddr(opAddr), .opWData(opWData), .opDone(opDone), .opRData(opRData),
        .memReq(memReq),
        .memWrite(memWrite), .memAddr(memAddr), .memWData(memWData), .memAck(memAck),
        .memRData(memRData), .eaStart(eaStart), .moveStart(moveStart), .srcMode(srcMode),
        .dstMode(dstMode), .opSize(opSize), .budgetClocks(budgetClocks),
        .budgetReads(budgetReads), .budgetWrites(budgetWrites), .lastClocks(),
        .lastReads(lastReads), .lastWrites(lastWrites), .lastWaits(lastWaits));

    ipf_mem_model u_mem (.clk(clk), .rst(rst), .slow(slow), .memReq(memReq),
        .memAddr(memAddr), .memAck(memAck), .memRData(memRData));

    // Stream word at an even address, high byte first
    function automatic logic [15:0] wd(input logic [19:0] a);
        logic [19:0] b;
        b = a + 20'h00001;
        return {a[7:0] ^ a[19:12] ^ 8'ha5, b[7:0] ^ b[19:12] ^ 8'ha5};
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("Errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic waitRdy;
        for (int i = 0; i < 400 && entryReady !== 1'b1; i++) @(posedge clk);
    endtask

    // Pulse order: next, consume, branch, exception
    task automatic flow(input logic [3:0] p, input logic [19:0] a, input logic [19:0] o,
                        input logic [19:0] x);
        qw.push_back({wd(o), wd(x), x});
        @(posedge clk);
        #1;
        {nextInstr, consumeExt, branchTaken, exceptTaken} = p;
        flowTarget = a;
        @(posedge clk);
        #1;
        {nextInstr, consumeExt, branchTaken, exceptTaken} = 4'h0;
        waitRdy();
    endtask

    task automatic bud(input logic k, input ipf_mode_t s, input ipf_mode_t d,
                       input ipf_size_t z, input logic [15:0] e);
        qb.push_back(e);
        @(posedge clk);
        #1;
        {eaStart, moveStart} = {!k, k};
        srcMode = s;
        dstMode = d;
        opSize = z;
        @(posedge clk);
        #1;
        {eaStart, moveStart} = 2'b00;
        repeat (3) @(posedge clk);
    endtask

    // Operand byte access, held until the done pulse
    task automatic opx(input logic w, input logic [19:0] a, input logic [7:0] d);
        logic [15:0] x;
        x = wd(a);
        qo.push_back({w, w ? d : x[15:8]});
        @(posedge clk);
        #1;
        {opReq, opWrite, opAddr, opWData} = {1'b1, w, a, d};
        for (int i = 0; i < 400 && opDone !== 1'b1; i++) @(posedge clk);
        #1;
        {opReq, opWrite} = 2'b00;
    endtask

    always @(posedge clk) begin
        if (entryReady === 1'b1 && pr === 1'b0 && qw.size() > 0) begin
            chk(64'({opWord, extWord, progCounter}), 64'(qw.pop_front()));
        end
        if (st[1] && qb.size() > 0) begin
            chk(64'({budgetClocks, budgetReads, budgetWrites}), 64'(qb.pop_front()));
        end
        if (memReq === 1'b1 && memWrite === 1'b1) begin
            wSeen = memWData;
        end
        if (opDone === 1'b1 && qo.size() > 0) begin
            oe = qo.pop_front();
            chk(64'(oe[8] ? wSeen : opRData), 64'(oe[7:0]));
        end
        pr = entryReady;
        st = {st[0], eaStart | moveStart};
        cyc++;
        // Hang guard
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        void'($urandom(32'h5259b947));
        qw.push_back({wd(20'h00000), wd(20'h00002), 20'h00002});
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        waitRdy();
        flow(4'h4, 20'h0, 20'h00000, 20'h00004);
        flow(4'h8, 20'h0, 20'h00004, 20'h00006);
        chk(64'({lastReads, lastWrites, lastWaits}), 64'h0600000c);
        slow = 1'b1;
        for (int i = 0; i < 4; i++) begin
            t = 20'($urandom()) & 20'hffff0;
            flow(i[0] ? 4'h1 : 4'h2, t, t, t + 20'h00002);
        end
        u = 20'($urandom());
        opx(1'b0, u, 8'h00);
        opx(1'b1, u + 20'h00001, 8'($urandom()));
        flow(4'h8, 20'h0, t + 20'h00002, t + 20'h00004);
        chk(64'(lastWrites), 64'h01);
        bud(1'b0, IPF_IND, IPF_IND, IPF_BYTE, 16'h0410);
        bud(1'b0, IPF_POSTINC, IPF_POSTINC, IPF_LONG, 16'h1040);
        bud(1'b0, IPF_PREDEC, IPF_PREDEC, IPF_WORD, 16'h0a20);
        bud(1'b0, IPF_PREDEC, IPF_PREDEC, IPF_LONG, 16'h1240);
        bud(1'b0, IPF_DISP, IPF_DISP, IPF_BYTE, 16'h0c30);
        bud(1'b0, IPF_PCINDEX, IPF_PCINDEX, IPF_LONG, 16'h1a60);
        bud(1'b0, IPF_INDEX, IPF_INDEX, IPF_WORD, 16'h1240);
        bud(1'b1, IPF_DREG, IPF_AREG, IPF_BYTE, 16'h0820);
        bud(1'b1, IPF_DREG, IPF_ABSL, IPF_BYTE, 16'h1c61);
        bud(1'b0, IPF_ABSL, IPF_DREG, IPF_BYTE, 16'h1450);
        bud(1'b1, IPF_DREG, IPF_IND, IPF_WORD, 16'h1022);
        bud(1'b1, IPF_IND, IPF_DREG, IPF_WORD, 16'h1040);
        chk(64'(qw.size() + qb.size() + qo.size()), 64'h0);
        summarize();
    end
endmodule
`default_nettype wire
